// ---- src/ssip_map.vh ----
`ifndef SSIP_MAP_VH
`define SSIP_MAP_VH
// ---------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------
`define SSIP_CMD_SET_WEL 8'h06
`define SSIP_CMD_CLR_WEL 8'h04
`define SSIP_CMD_STAT_WR 8'h01
`define SSIP_CMD_STAT_RD 8'h05
`define SSIP_CMD_RELOAD 8'h07
`define SSIP_CMD_MEM_WR 3'b010
`define SSIP_CMD_MEM_RD 3'b011
`define SSIP_CMD_A8_BIT 3
// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define SSIP_ST_BUSY 0
`define SSIP_ST_WEL 1
`define SSIP_ST_BP_LO 2
`define SSIP_ST_BP_HI 3
`define SSIP_ST_WD_LO 4
`define SSIP_ST_WD_HI 5
`define SSIP_ST_RG 6
`define SSIP_ST_HPE 7
`define SSIP_ST_NV_RESET 6'h00
// ---------------------------------------------------------------
// Address ranges
// ---------------------------------------------------------------
`define SSIP_ADDR_BLK3 9'h0c0
`define SSIP_ADDR_BLK2 9'h080
`define SSIP_ADDR_USER_END 9'h0ff
`define SSIP_ADDR_EEREG 9'h100
`define SSIP_ADDR_ROM 9'h110
`define SSIP_ADDR_REG 9'h120
`define SSIP_ADDR_REG_END 9'h135
`define SSIP_ADDR_VOL_END 9'h125
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SSIP_PROG_MS 10
`define SSIP_CLK_MHZ 50
`define SSIP_PROG_CYC (`SSIP_PROG_MS * 1000 * `SSIP_CLK_MHZ)
`define SSIP_FIFO_DEPTH 16
`define SSIP_FIFO_AW 4
`endif

// ---- src/ssip_sync.v ----
`timescale 1ns/1ps
module ssip_sync (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_async,
    output reg o_sync
);
    reg meta;
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            meta <= 1'b1;
            o_sync <= 1'b1;
        end else if (i_ce) begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// ---- src/ssip_fifo.v ----
`timescale 1ns/1ps
module ssip_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_flush,
    input wire i_valid,
    output wire o_ready,
    input wire [WIDTH-1:0] i_data,
    output wire o_valid,
    input wire i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rd_ptr[AW-1:0]];
    always @(posedge i_ref_clk) begin
        if (i_ce && i_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (i_flush) begin
                wr_ptr <= {(AW+1){1'b0}};
                rd_ptr <= {(AW+1){1'b0}};
            end else begin
                if (i_valid && !full) begin
                    wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
                end
                if (i_ready && !empty) begin
                    rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ---- src/ssip_slave.v ----
`timescale 1ns/1ps
`include "ssip_map.vh"
// Function
// R1: Low chip select selects; deselected output floats.
// R2: Chip select rise after valid write starts programming that always completes.
// R3: Nothing starts after power-up until chip select has been seen low.
// R4: Sample input on clock rise; change output only after clock fall.
// R5: Whole bytes, MSB first; every sequence opens with a host byte.
// R6: First byte after select is the instruction; then collect address and data.
// R7: Mode 0,0 or 1,1 taken from clock level at select fall.
// R8: Host keeps select low during transfer and raises it to end.
// R9: First read bit appears after the falling edge following last address bit.
// R10: One address byte; ninth address bit is instruction bit 3.
// R11: Code 06h sets write latch, 04h clears it, no further bytes.
// R12: Code 01h writes status byte; 05h shifts status out.
// R13: Code 07h reloads registers 120h to 125h with defaults.
// R14: Pattern X010b takes address and data bytes to write.
// R15: Pattern X011b takes address and returns data bytes.
// R16: Writes refused unless latch set; latch cleared after successful write.
// R17: Latch zero after reset; cleared by disable, status write, memory write.
// R18: Status bits 7:2 writable unless protect enable set and pin low.
// R19: Block protect field guards 0C0h, 080h or all user memory.
// R20: Register guard blocks writes at 120h and above.
// R21: Watchdog timeout select field chooses one of four timeouts.
// R22: Busy bit reads one during programming.
// R23: Status read always executes; others refused while busy.
// R24: Multiple status write bytes: last whole byte is used.
// R25: Repeated status read refreshes busy bit at each LSB.
// R26: Unknown instruction ignored until chip select rises.
module ssip_slave #(
    parameter PROG_CYCLES = `SSIP_PROG_CYC
) (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_chip_select_low_n,
    input wire i_sck,
    input wire i_si,
    input wire i_hw_protect_pin_low_n,
    output reg o_so,
    output reg o_so_oe,
    output reg o_wr_valid,
    output reg [9:0] o_wr_addr,
    output reg [7:0] o_wr_data,
    input wire i_wr_ready,
    output reg o_rd_req,
    output reg [8:0] o_rd_addr,
    input wire [7:0] i_rd_data,
    output reg o_prog_start,
    output reg o_reload,
    output reg o_mode11,
    output reg [7:0] o_status
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    wire cs_n_s;
    wire sck_s;
    wire si_s;
    wire wp_s;
    ssip_sync u_sync_cs (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_async(i_chip_select_low_n), .o_sync(cs_n_s));
    ssip_sync u_sync_sck (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_async(i_sck), .o_sync(sck_s));
    ssip_sync u_sync_si (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_async(i_si), .o_sync(si_s));
    ssip_sync u_sync_wp (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_async(i_hw_protect_pin_low_n), .o_sync(wp_s));

    reg cs_d;
    reg sck_d;
    wire cs_fall = cs_d && !cs_n_s;
    wire cs_rise = !cs_d && cs_n_s;
    wire sck_rise = !sck_d && sck_s && !cs_n_s;
    wire sck_fall = sck_d && !sck_s && !cs_n_s;

    // ---------------------------------------------------------------
    // Sequence state
    // ---------------------------------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_CMD = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_WDATA = 3'd3;
    localparam ST_RDATA = 3'd4;
    localparam ST_SWR = 3'd5;
    localparam ST_SRD = 3'd6;
    localparam ST_DONE = 3'd7;

    reg [2:0] state;
    reg seen_cs_low;
    reg [7:0] shift;
    reg [2:0] bit_cnt;
    reg [7:0] cmd;
    reg [8:0] addr;
    reg [7:0] tx;
    reg wel;
    reg [5:0] nv;
    reg busy;
    reg [31:0] prog_cnt;
    reg pend_ee;
    reg pend_st;
    reg [5:0] pend_nv;
    reg bytes_ok;
    reg any_reg_wr;

    wire [7:0] shift_in = {shift[6:0], si_s};
    wire byte_done = sck_rise && (bit_cnt == 3'd7);
    wire [7:0] status_now = {nv, wel, busy};
    wire st_writable = !nv[`SSIP_ST_HPE-2] || wp_s;

    // Protection check for a target address
    function addr_protected;
        input [8:0] a;
        input [1:0] bp;
        input rg;
        begin
            addr_protected = 1'b0;
            if (a <= `SSIP_ADDR_USER_END) begin
                case (bp)
                    2'b01: addr_protected = (a >= `SSIP_ADDR_BLK3);
                    2'b10: addr_protected = (a >= `SSIP_ADDR_BLK2);
                    2'b11: addr_protected = 1'b1;
                    default: addr_protected = 1'b0;
                endcase
            end else if (a >= `SSIP_ADDR_REG) begin
                addr_protected = rg;
            end else if (a >= `SSIP_ADDR_ROM) begin
                addr_protected = 1'b1;
            end
        end
    endfunction

    wire [1:0] bp_f = nv[`SSIP_ST_BP_HI-2:`SSIP_ST_BP_LO-2];
    wire rg_f = nv[`SSIP_ST_RG-2];

    // ---------------------------------------------------------------
    // Write byte queue
    // ---------------------------------------------------------------
    reg push;
    reg [16:0] push_data;
    wire fifo_ready;
    wire fifo_valid;
    wire [16:0] fifo_data;
    wire pop = fifo_valid && (!o_wr_valid || i_wr_ready);
    ssip_fifo #(
        .WIDTH(17),
        .DEPTH(`SSIP_FIFO_DEPTH),
        .AW(`SSIP_FIFO_AW)
    ) u_wr_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_flush(1'b0),
        .i_valid(push),
        .o_ready(fifo_ready),
        .i_data(push_data),
        .o_valid(fifo_valid),
        .i_ready(pop),
        .o_data(fifo_data)
    );

    // ---------------------------------------------------------------
    // Main sequencer
    // ---------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            cs_d <= 1'b1;
            sck_d <= 1'b0;
            state <= ST_IDLE;
            seen_cs_low <= 1'b0;
            shift <= 8'h00;
            bit_cnt <= 3'd0;
            cmd <= 8'h00;
            addr <= 9'h000;
            tx <= 8'h00;
            wel <= 1'b0;
            nv <= `SSIP_ST_NV_RESET;
            busy <= 1'b0;
            prog_cnt <= 32'h0;
            pend_ee <= 1'b0;
            pend_st <= 1'b0;
            pend_nv <= 6'h00;
            bytes_ok <= 1'b1;
            any_reg_wr <= 1'b0;
            push <= 1'b0;
            push_data <= 17'h00000;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_addr <= 10'h000;
            o_wr_data <= 8'h00;
            o_rd_req <= 1'b0;
            o_rd_addr <= 9'h000;
            o_prog_start <= 1'b0;
            o_reload <= 1'b0;
            o_mode11 <= 1'b0;
            o_status <= 8'h00;
        end else if (i_ce) begin
            cs_d <= cs_n_s;
            sck_d <= sck_s;
            o_prog_start <= 1'b0;
            o_reload <= 1'b0;
            o_rd_req <= 1'b0;
            o_status <= status_now;
            push <= 1'b0;
            // Output stage holds each byte until the consumer is ready
            if (pop) begin
                o_wr_valid <= 1'b1;
                o_wr_addr <= {1'b0, fifo_data[16:8]};
                o_wr_data <= fifo_data[7:0];
            end else if (i_wr_ready) begin
                o_wr_valid <= 1'b0;
            end
            // Programming runs to the end regardless of chip select
            if (busy) begin
                if (prog_cnt == 32'h1) begin
                    busy <= 1'b0; // R2 R22
                    wel <= 1'b0; // R16 R17
                    if (pend_st) begin
                        nv <= pend_nv;
                    end
                    pend_st <= 1'b0;
                end
                prog_cnt <= prog_cnt - 32'h1;
            end
            o_so_oe <= !cs_n_s; // R1
            if (cs_fall) begin
                seen_cs_low <= 1'b1; // R3
                o_mode11 <= sck_s; // R7
                state <= ST_CMD; // R6
                bit_cnt <= 3'd0;
                pend_ee <= 1'b0;
                bytes_ok <= 1'b1;
                any_reg_wr <= 1'b0;
            end else if (cs_rise) begin
                state <= ST_IDLE;
                // Incomplete byte or protection cancels the cycle
                if (pend_ee && bytes_ok && (bit_cnt == 3'd0) && wel && !busy) begin
                    busy <= 1'b1; // R2
                    prog_cnt <= PROG_CYCLES;
                    o_prog_start <= 1'b1;
                end else if (any_reg_wr) begin
                    wel <= 1'b0; // R16
                end
                if (!(pend_ee && bytes_ok && bit_cnt == 3'd0)) begin
                    pend_st <= busy ? pend_st : 1'b0;
                end
            end else if (seen_cs_low && sck_rise && state != ST_IDLE) begin
                shift <= shift_in; // R4 R5
                bit_cnt <= bit_cnt + 3'd1;
                if (byte_done) begin
                    case (state)
                        ST_CMD: begin
                            cmd <= shift_in;
                            addr[8] <= shift_in[`SSIP_CMD_A8_BIT]; // R10
                            if (shift_in == `SSIP_CMD_STAT_RD) begin
                                state <= ST_SRD; // R12 R23
                                tx <= status_now;
                            end else if (busy) begin
                                state <= ST_DONE; // R23
                            end else if (shift_in == `SSIP_CMD_SET_WEL) begin
                                wel <= 1'b1; // R11
                                state <= ST_DONE;
                            end else if (shift_in == `SSIP_CMD_CLR_WEL) begin
                                wel <= 1'b0; // R11 R17
                                state <= ST_DONE;
                            end else if (shift_in == `SSIP_CMD_STAT_WR) begin
                                state <= ST_SWR; // R12
                            end else if (shift_in == `SSIP_CMD_RELOAD) begin
                                o_reload <= 1'b1; // R13
                                state <= ST_DONE;
                            end else if (shift_in[7:4] == 4'h0 &&
                                         (shift_in[2:0] == `SSIP_CMD_MEM_WR ||
                                          shift_in[2:0] == `SSIP_CMD_MEM_RD)) begin
                                state <= ST_ADDR; // R14 R15
                            end else begin
                                state <= ST_DONE; // R26
                            end
                        end
                        ST_ADDR: begin
                            addr[7:0] <= shift_in; // R10
                            if (cmd[2:0] == `SSIP_CMD_MEM_RD) begin
                                state <= ST_RDATA; // R15
                                o_rd_req <= 1'b1;
                                o_rd_addr <= {addr[8], shift_in};
                            end else begin
                                state <= ST_WDATA; // R14
                            end
                        end
                        ST_WDATA: begin
                            // Writes need the latch and an unguarded target
                            if (wel && fifo_ready &&
                                !addr_protected(addr, bp_f, rg_f)) begin // R16 R19 R20
                                push <= 1'b1;
                                push_data <= {addr, shift_in};
                                if (addr >= `SSIP_ADDR_REG) begin
                                    any_reg_wr <= 1'b1;
                                end else begin
                                    pend_ee <= 1'b1;
                                end
                            end else begin
                                bytes_ok <= 1'b0;
                            end
                            if (addr == `SSIP_ADDR_REG_END) begin
                                addr <= `SSIP_ADDR_REG;
                            end else if (addr < `SSIP_ADDR_EEREG) begin
                                addr <= {addr[8:4], addr[3:0] + 4'h1};
                            end else begin
                                addr <= addr + 9'h001;
                            end
                        end
                        ST_SWR: begin
                            if (wel && st_writable) begin // R16 R18
                                pend_ee <= 1'b1;
                                pend_st <= 1'b1;
                                pend_nv <= shift_in[7:2]; // R24 R21
                            end else begin
                                pend_ee <= 1'b0;
                            end
                        end
                        ST_RDATA: begin
                            o_rd_req <= 1'b1;
                            o_rd_addr <= addr + 9'h001;
                            addr <= addr + 9'h001;
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (sck_fall) begin
                // Output moves only after a falling edge
                if (state == ST_SRD || state == ST_RDATA) begin
                    if (bit_cnt == 3'd0) begin
                        if (state == ST_SRD) begin
                            tx <= {status_now[6:0], 1'b0}; // R25
                            o_so <= status_now[7];
                        end else begin
                            tx <= {i_rd_data[6:0], 1'b0}; // R9
                            o_so <= i_rd_data[7];
                        end
                    end else begin
                        o_so <= tx[7]; // R4
                        tx <= {tx[6:0], 1'b0};
                        if (state == ST_SRD && bit_cnt == 3'd7) begin
                            o_so <= busy; // R25
                        end
                    end
                end
            end
        end
    end
endmodule

// ---- dv/ssip_slave_asserts.sv ----
`timescale 1ns/1ps
module ssip_slave_chk #(
    parameter PROG_CYCLES = 500000
) (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_chip_select_low_n,
    input wire i_sck,
    input wire o_so,
    input wire o_so_oe,
    input wire o_wr_valid,
    input wire [9:0] o_wr_addr,
    input wire o_rd_req,
    input wire o_prog_start,
    input wire o_reload,
    input wire o_mode11,
    input wire [7:0] o_status
);
    reg sck_q;
    integer fall_age;
    integer busy_len;
    wire [1:0] bp = o_status[3:2];
    wire blk_hit = (bp == 2'h3) || (bp == 2'h2 && o_wr_addr[7]) ||
        (bp == 2'h1 && o_wr_addr[7:6] == 2'h3);
    // Age since the serial clock pin last fell, length of the current busy spell
    always @(posedge i_ref_clk) begin
        sck_q <= i_sck;
        fall_age <= (!i_reset_n || (sck_q && !i_sck)) ? 0 : fall_age + 1;
        busy_len <= (!i_reset_n || !o_status[0]) ? 0 : busy_len + 1;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_cs_idle; i_chip_select_low_n [*6]; endsequence
    sequence s_prog_go; i_chip_select_low_n ##[1:2] o_status[0]; endsequence
    property p_so_float; s_cs_idle |-> !o_so_oe; endproperty
    a_so_float: assert property (p_so_float) else $error("output enabled while idle");
    property p_so_edge; o_so_oe && $past(o_so_oe) && $changed(o_so) |-> fall_age <= 6; endproperty
    a_so_edge: assert property (p_so_edge) else $error("output moved without clock fall");
    property p_mode; $fell(i_chip_select_low_n) |-> ##6 (o_mode11 == $past(i_sck, 6)); endproperty
    a_mode: assert property (p_mode) else $error("clock mode not captured");
    property p_prog; o_prog_start |-> s_prog_go; endproperty
    a_prog: assert property (p_prog) else $error("program start without busy");
    property p_busy_len;
        $fell(o_status[0]) |-> busy_len >= PROG_CYCLES - 2 && busy_len <= PROG_CYCLES + 2;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_wel_done; $fell(o_status[0]) |-> !o_status[1]; endproperty
    a_wel_done: assert property (p_wel_done) else $error("latch kept after write");
    property p_wr_latch; $rose(o_wr_valid) |-> o_status[1]; endproperty
    a_wr_latch: assert property (p_wr_latch) else $error("write without latch");
    property p_blk; o_wr_valid && !o_wr_addr[8] |-> !blk_hit; endproperty
    a_blk: assert property (p_blk) else $error("write into protected block");
    property p_guard; o_wr_valid && o_wr_addr >= 10'h120 |-> !o_status[6]; endproperty
    a_guard: assert property (p_guard) else $error("write into guarded registers");
    property p_busy_quiet; o_status[0] |-> !o_rd_req && !o_reload && !$rose(o_wr_valid); endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("command run while busy");
endmodule
bind ssip_slave ssip_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_chip_select_low_n(i_chip_select_low_n),
    .i_sck(i_sck), .o_so(o_so), .o_so_oe(o_so_oe), .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr), .o_rd_req(o_rd_req), .o_prog_start(o_prog_start),
    .o_reload(o_reload), .o_mode11(o_mode11), .o_status(o_status)
);

// ---- dv/ssip_host_model.sv ----
`timescale 1ns/1ps
module ssip_host_model (
    input wire i_ref_clk,
    input wire i_so,
    output reg o_cs_n,
    output reg o_sck,
    output reg o_si
);
    reg mode11;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        mode11 = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Clock level held steady on both sides of the select edge
    task automatic start(input logic m);
        mode11 = m;
        o_sck = m;
        tick(4);
        o_cs_n = 1'b0;
        tick(4);
    endtask
    // Output bit is taken at the end of the high phase, where it stands
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_sck = 1'b0;
            o_si = tx[i];
            tick(4);
            o_sck = 1'b1;
            tick(4);
            rx[i] = i_so;
        end
    endtask
    task automatic stop();
        o_sck = mode11;
        tick(4);
        o_cs_n = 1'b1;
        o_si = ~o_si;
        tick(8);
    endtask
endmodule

// ---- dv/spi_slave_instruction_protect_tb.sv ----
`timescale 1ns/1ps
module spi_slave_instruction_protect_tb;
    localparam int PROG = 400;
    reg i_ref_clk = 1'b0;
    reg i_reset_n = 1'b0;
    reg i_hw_protect_pin_low_n = 1'b1;
    reg i_wr_ready = 1'b0;
    reg [2:0] rdy_cnt = 3'h0;
    wire cs_n, sck, si, so, so_oe, wr_valid, rd_req, prog_start, reload, mode11;
    wire [9:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] status;
    wire [8:0] rd_addr;
    wire so_pin = so_oe ? so : 1'bz;
    reg [7:0] rd_data = 8'h00;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_wr = 0;
    int n_reload = 0;
    int n_prog = 0;
    reg [16:0] last_wr = 17'h0;
    logic [7:0] r1, rn;
    logic [7:0] bad [3] = '{8'h08, 8'h12, 8'h83};
    always #10 i_ref_clk = ~i_ref_clk;
    ssip_slave #(.PROG_CYCLES(PROG)) i_dut (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
        .i_chip_select_low_n(cs_n), .i_sck(sck), .i_si(si),
        .i_hw_protect_pin_low_n(i_hw_protect_pin_low_n), .o_so(so), .o_so_oe(so_oe),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .i_wr_ready(i_wr_ready), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
        .o_prog_start(prog_start), .o_reload(reload), .o_mode11(mode11), .o_status(status)
    );
    ssip_host_model i_host (
        .i_ref_clk(i_ref_clk), .i_so(so_pin), .o_cs_n(cs_n), .o_sck(sck), .o_si(si)
    );
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (wr_valid && i_wr_ready) begin
            n_wr <= n_wr + 1;
            last_wr <= {wr_addr[8:0], wr_data};
        end
        n_reload <= n_reload + reload;
        n_prog <= n_prog + prog_start;
        if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5a;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // Write consumer stalls three cycles out of four
    always @(posedge i_ref_clk) begin
        #1;
        rdy_cnt = rdy_cnt + 3'h1;
        i_wr_ready = rdy_cnt[1] & rdy_cnt[0];
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic m, input logic [7:0] code, input int n,
                      input logic [7:0] b1, input logic [7:0] b2);
        logic [7:0] rx;
        i_host.start(m);
        i_host.xfer(code, rx);
        for (int k = 0; k < n; k++) begin
            i_host.xfer(k == 0 ? b1 : b2, rx);
            if (k == 0) r1 = rx;
        end
        rn = rx;
        i_host.stop();
    endtask
    task automatic wait_idle();
        int k = 0;
        while (status[0] !== 1'b0 && k < 2000) begin
            @(posedge i_ref_clk);
            #1;
            k++;
        end
        chk(status[0], 1'b0);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_ref_clk);
        #1;
        i_reset_n = 1'b1;
        @(posedge i_ref_clk);
        #1;
        chk(status, 8'h00);
        chk(so_oe, 1'b0);
        op(1'b0, 8'h05, 1, 8'h00, 8'h00);
        chk(rn, 8'h00);
        chk(mode11, 1'b0);
        done("reset values");
        op(1'b1, 8'h06, 0, 8'h00, 8'h00);
        chk(mode11, 1'b1);
        op(1'b1, 8'h05, 1, 8'h00, 8'h00);
        chk(rn, 8'h02);
        foreach (bad[i]) begin
            op(1'b1, bad[i], 2, 8'h40, 8'h11);
        end
        chk(n_wr, 0);
        chk(status, 8'h02);
        op(1'b1, 8'h04, 0, 8'h00, 8'h00);
        chk(status, 8'h00);
        op(1'b1, 8'h01, 1, 8'h0c, 8'h00);
        chk(status, 8'h00);
        chk(n_prog, 0);
        done("write latch");
        op(1'b0, 8'h06, 0, 8'h00, 8'h00);
        op(1'b0, 8'h01, 2, 8'hff, 8'h8c);
        chk(n_prog, 1);
        op(1'b0, 8'h07, 0, 8'h00, 8'h00);
        chk(n_reload, 0);
        op(1'b0, 8'h05, 8, 8'h00, 8'h00);
        chk(r1, 8'h03);
        chk(rn, 8'h8c);
        wait_idle();
        done("status write");
        op(1'b0, 8'h06, 0, 8'h00, 8'h00);
        op(1'b0, 8'h02, 2, 8'h10, 8'h77);
        chk(n_wr, 0);
        i_hw_protect_pin_low_n = 1'b0;
        op(1'b0, 8'h01, 1, 8'h00, 8'h00);
        chk(status, 8'h8e);
        i_hw_protect_pin_low_n = 1'b1;
        op(1'b0, 8'h01, 1, 8'h08, 8'h00);
        chk(n_prog, 2);
        wait_idle();
        chk(status, 8'h08);
        done("status protection");
        op(1'b0, 8'h06, 0, 8'h00, 8'h00);
        op(1'b0, 8'h02, 2, 8'h90, 8'h11);
        chk(n_wr, 0);
        op(1'b0, 8'h02, 4, 8'h7e, 8'ha5);
        chk(n_wr, 3);
        chk(last_wr, {9'h070, 8'ha5});
        wait_idle();
        chk(status, 8'h08);
        done("memory write");
        op(1'b1, 8'h06, 0, 8'h00, 8'h00);
        op(1'b1, 8'h0a, 2, 8'h22, 8'h5c);
        chk(last_wr, {9'h122, 8'h5c});
        chk(status, 8'h08);
        op(1'b1, 8'h06, 0, 8'h00, 8'h00);
        op(1'b1, 8'h01, 1, 8'h74, 8'h00);
        wait_idle();
        op(1'b1, 8'h06, 0, 8'h00, 8'h00);
        op(1'b1, 8'h0a, 2, 8'h23, 8'h66);
        chk(n_wr, 4);
        chk(status, 8'h76);
        op(1'b1, 8'h02, 2, 8'hc5, 8'h99);
        chk(n_wr, 4);
        done("register guard");
        op(1'b0, 8'h0b, 2, 8'h05, 8'h00);
        chk(rn, 8'h5f);
        op(1'b1, 8'h03, 2, 8'h33, 8'h00);
        chk(rn, 8'h69);
        op(1'b1, 8'h07, 0, 8'h00, 8'h00);
        chk(n_reload, 1);
        done("read and reload");
        report_and_stop();
    end
endmodule
